// ===== bench/ccd_clock_sequencer_bench.sv
// Self-checking bench for the CCD clock sequencer
`default_nettype none
module ccd_clock_sequencer_bench import ccdseq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR = 3; // Rows per frame, shortened
  localparam int NP = 6; // Pixels per line, shortened
  // Stimulus, changed 2 ns after each rising edge
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic pix_ready_i = 1'b0;
  logic [31:0] integ_cycles_i = 32'h0;
  // Design outputs
  logic busy_o, frame_done_o, va, vb, ha, hb, fh, rg, pix_valid_o;
  logic [VIDEO_W-1:0] video_i;
  ccdseq_pixel_t pix_data_o;
  ccdseq_pixel_t got[$]; // Pixels taken off the stream
  int err_total = 0;
  int n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  // Log every accepted pixel
  always @(posedge clk_i) begin
    if (pix_valid_o === 1'b1 && pix_ready_i) got.push_back(pix_data_o);
  end
  ccdseq_sequencer #(.ROWS(NR), .PIXELS(NP), .LINE_CYC(40), .VPULSE_CYC(4),
    .SETTLE_CYC(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .integ_cycles_i(integ_cycles_i), .busy_o(busy_o), .frame_done_o(frame_done_o),
    .vertical_phase_a_o(va), .vertical_phase_b_o(vb), .horizontal_phase_a_o(ha),
    .horizontal_phase_b_o(hb), .final_horizontal_phase_o(fh), .output_reset_gate_o(rg),
    .video_i(video_i), .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
    .pix_ready_i(pix_ready_i));
  ccdseq_sensor_model #(.ROWS(NR)) u_sensor (.rst_i(rst_i), .vertical_phase_a_i(va),
    .vertical_phase_b_i(vb), .final_horizontal_phase_i(fh), .video_o(video_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic end_sim;
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Reset, then the pins must sit at their idle levels
  task automatic t_reset;
    rst_i = 1'b1;
    cyc(12);
    rst_i = 1'b0;
    cyc(1);
    chk("idle_pins", 32'h016, {busy_o, frame_done_o, va, vb, ha, hb, fh, rg, pix_valid_o});
  endtask : t_reset
  // One frame; start held into readout; optional consumer stall fills the buffer
  task automatic t_frame(input int integ, input bit stall, output int span);
    int n;
    t_reset();
    got.delete();
    start_i = 1'b1;
    integ_cycles_i = integ;
    pix_ready_i = !stall;
    span = 0;
    while (va !== 1'b1 && span < 1000) begin
      cyc(1);
      span++;
    end
    start_i = 1'b0;
    if (stall) begin
      cyc(150);
      chk("stalled", 32'h3, {pix_valid_o, fh});
      pix_ready_i = 1'b1;
    end
    n = 0;
    while (frame_done_o !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk("done", 32'h1, n < 5000);
    cyc(20);
    chk("vert_after", 32'h0, {va, vb});
    chk("count", NR * NP, got.size());
    foreach (got[i])
      chk("pixel", {12'(i / NP), i % NP == NP - 1, 8'(i / NP), 8'(i % NP)}, got[i]);
  endtask : t_frame
  // Two frames; the integration lengths must show up as exactly their gap
  task automatic t_integ;
    int s0, s1;
    t_frame(30, 1'b0, s0);
    t_frame(80, 1'b1, s1);
    chk("integ_gap", 32'd50, s1 - s0);
  endtask : t_integ
  // Main sequence
  initial begin
    t_integ();
    end_sim();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    err_total++;
    end_sim();
  end
endmodule : ccd_clock_sequencer_bench
`default_nettype wire

// ===== bench/ccdseq_sensor_model.sv
// Behavioural sensor: counts rows and packets and presents them as video
`default_nettype none
module ccdseq_sensor_model
  import ccdseq_pkg::*;
#(
  parameter int unsigned ROWS = ROW_COUNT
) (
  // Reset from the bench
  input wire logic rst_i,
  // Sensor clock pins
  input wire logic vertical_phase_a_i,
  input wire logic vertical_phase_b_i,
  input wire logic final_horizontal_phase_i,
  // Sample seen by the converter
  output logic [VIDEO_W-1:0] video_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] vrow = 12'h000; // Rows moved down the vertical register
  logic [11:0] hrow; // Row now in the horizontal register
  logic [7:0] dumps = 8'h00; // Final phase falls so far, wrapping
  logic [7:0] base = 8'h00; // Fall count when the row was loaded
  // Each vertical A fall steps the image one row
  always @(posedge rst_i or negedge vertical_phase_a_i) begin
    if (rst_i)
      vrow <= 12'h000;
    else
      vrow <= vrow + 12'h001;
  end
  // Vertical B fall loads the leading row into the horizontal register
  always @(negedge vertical_phase_b_i) begin
    hrow <= vrow - 12'h001;
    base <= dumps;
  end
  // Each final phase fall puts the next packet on the sense node
  always @(negedge final_horizontal_phase_i) begin
    dumps <= dumps + 8'h01;
  end
  // Rows past the last real one are empty; video tags row and packet
  assign video_o = (hrow >= ROWS) ? '0 : {hrow[7:0], 8'(dumps - base - 8'h01)};
endmodule : ccdseq_sensor_model
`default_nettype wire

// ===== bench/ccdseq_sequencer_properties.sv
// Pin timing checks for the clock sequencer, bound to its top module
`default_nettype none
module ccdseq_sequencer_props
  import ccdseq_pkg::*;
#(
  parameter int unsigned ROWS = ROW_COUNT,
  parameter int unsigned PIXELS = PIXEL_COUNT,
  parameter int unsigned LINE_CYC = LINE_MIN_CYC,
  parameter int unsigned VPULSE_CYC = V_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = VH_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic busy_o,
  input wire logic frame_done_o,
  input wire logic vertical_phase_a_o,
  input wire logic vertical_phase_b_o,
  input wire logic horizontal_phase_a_o,
  input wire logic horizontal_phase_b_o,
  input wire logic final_horizontal_phase_o,
  input wire logic output_reset_gate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Short aliases keep the properties readable
  wire va = vertical_phase_a_o;
  wire vb = vertical_phase_b_o;
  wire ha = horizontal_phase_a_o;
  wire fh = final_horizontal_phase_o;
  logic aq, bq, fq; // Last cycle's pin levels
  int acnt, bcnt, pcnt, rcnt; // Cycles since edges, pixels in line, rows in frame
  int fcyc; // Cycles since the last final phase fall
  // acnt starts at LINE_CYC after reset so the first row is not judged short
  always_ff @(posedge clk_i) begin
    aq <= va;
    bq <= vb;
    fq <= fh;
    acnt <= rst_i ? int'(LINE_CYC) : (va && !aq) ? 1 : acnt + 1;
    bcnt <= (vb != bq) ? 1 : bcnt + 1;
    pcnt <= (bq && !vb) ? 0 : pcnt + int'(fq && !fh);
    rcnt <= (rst_i || frame_done_o) ? 0 : rcnt + int'(aq && !va);
    fcyc <= (fq && !fh) ? 1 : fcyc + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_comp; horizontal_phase_b_o == !ha; endproperty
  a_comp: assert property (p_comp) else $error("horizontal phases overlap");
  property p_rg; output_reset_gate_o == fh; endproperty
  a_rg: assert property (p_rg) else $error("reset gate out of step");
  property p_half; $fell(fh) |=> fh; endproperty
  a_half: assert property (p_half) else $error("pixel low half wrong");
  property p_pix_per; $fell(fh) |-> fcyc >= PIX_CYC; endproperty
  a_pix_per: assert property (p_pix_per) else $error("pixel period short");
  property p_va_w; $fell(va) |-> acnt >= VPULSE_CYC; endproperty
  a_va_w: assert property (p_va_w) else $error("vertical A pulse short");
  property p_vb_w; $fell(vb) |-> bcnt >= VPULSE_CYC; endproperty
  a_vb_w: assert property (p_vb_w) else $error("vertical B pulse short");
  property p_settle; $fell(ha) |-> bcnt >= SETTLE_CYC; endproperty
  a_settle: assert property (p_settle) else $error("shift began too soon");
  property p_vb_ha; $fell(vb) |-> ha && $past(ha); endproperty
  a_vb_ha: assert property (p_vb_ha) else $error("horizontal A low at load");
  property p_line; $rose(va) |-> acnt >= LINE_CYC; endproperty
  a_line: assert property (p_line) else $error("line time short");
  property p_pix; frame_done_o |-> pcnt == PIXELS; endproperty
  a_pix: assert property (p_pix) else $error("pixel count per line wrong");
  property p_rows; frame_done_o |-> rcnt == ROWS; endproperty
  a_rows: assert property (p_rows) else $error("row count per frame wrong");
  property p_idle; !busy_o |-> !va && !vb; endproperty
  a_idle: assert property (p_idle) else $error("vertical clocks moved in idle");
  property p_done; frame_done_o |=> !busy_o; endproperty
  a_done: assert property (p_done) else $error("no return to idle");
endmodule : ccdseq_sequencer_props
bind ccdseq_sequencer ccdseq_sequencer_props #(.ROWS(ROWS), .PIXELS(PIXELS),
  .LINE_CYC(LINE_CYC), .VPULSE_CYC(VPULSE_CYC), .SETTLE_CYC(SETTLE_CYC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .busy_o(busy_o), .frame_done_o(frame_done_o),
  .vertical_phase_a_o(vertical_phase_a_o), .vertical_phase_b_o(vertical_phase_b_o),
  .horizontal_phase_a_o(horizontal_phase_a_o), .horizontal_phase_b_o(horizontal_phase_b_o),
  .final_horizontal_phase_o(final_horizontal_phase_o),
  .output_reset_gate_o(output_reset_gate_o));
`default_nettype wire

// ===== rtl/ccdseq_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`default_nettype none
module ccdseq_fifo #(
  parameter int unsigned WIDTH = 29,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
  logic [AW-1:0] wr_reg, wr_next;  // Write pointer
  logic [AW-1:0] rd_reg, rd_next;  // Read pointer
  logic [AW:0] cnt_reg, cnt_next;  // Fill level
  logic vld_reg, vld_next;  // Head word present
  logic [WIDTH-1:0] head_reg, head_next;  // Registered copy of the oldest word
  logic push, pop;

  // Next pointers and level; full and empty come straight from the level
  always_comb begin
    push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_reg != '0);
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    vld_next = (cnt_next != '0);
    // A word written into the slot that becomes the head bypasses storage,
    // so the drain side sees it one cycle after the push as before
    head_next = (push && (wr_reg == rd_next)) ? in_data_i : mem_reg[rd_next];
  end

  // Register pointers and storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      vld_reg <= vld_next;
    end
    head_reg <= head_next;
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = vld_reg;
  assign out_data_o = head_reg;
endmodule : ccdseq_fifo
`default_nettype wire

// ===== rtl/ccdseq_pkg.sv
// Constants and carrier types shared by the clock sequencer files
`default_nettype none
package ccdseq_pkg;
  // Clock period and documented times, in picoseconds
  localparam int unsigned CLK_PS = 25000;
  localparam int unsigned PIX_MIN_PS = 41670;
  localparam int unsigned V_PULSE_MIN_PS = 8000000;
  localparam int unsigned VH_SETTLE_MIN_PS = 5000000;
  localparam int unsigned LINE_MIN_PS = 219000000;
  // Cycle counts; least times round up
  localparam int unsigned PIX_CYC = (PIX_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned PIX_HALF_CYC = (PIX_CYC + 1) / 2;
  localparam int unsigned V_PULSE_CYC = (V_PULSE_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned VH_SETTLE_CYC = (VH_SETTLE_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned LINE_MIN_CYC = (LINE_MIN_PS + CLK_PS - 1) / CLK_PS;
  // Frame geometry
  localparam int unsigned ROW_COUNT = 3695;
  localparam int unsigned PIXEL_COUNT = 4641;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned VIDEO_W = 16;
  // Sequencer states
  typedef enum logic [2:0] {
    CCDSEQ_IDLE = 3'h0,
    CCDSEQ_INTEG = 3'h1,
    CCDSEQ_VA_HIGH = 3'h2,
    CCDSEQ_VB_HIGH = 3'h3,
    CCDSEQ_SETTLE = 3'h4,
    CCDSEQ_SHIFT = 3'h5,
    CCDSEQ_LINE_PAD = 3'h6
  } ccdseq_state_t;
  // Sensor clock pins
  typedef struct packed {
    logic vertical_phase_a;
    logic vertical_phase_b;
    logic horizontal_phase_a;
    logic horizontal_phase_b;
    logic final_horizontal_phase;
    logic output_reset_gate;
  } ccdseq_clocks_t;
  // Pin levels in reset and between frames: horizontal A, final phase and
  // reset gate high, vertical phases and horizontal B low
  localparam ccdseq_clocks_t PINS_IDLE = 6'h0b;
  // One sampled pixel with its place in the frame
  typedef struct packed {
    logic [11:0] row;
    logic line_end;
    logic [VIDEO_W-1:0] video;
  } ccdseq_pixel_t;
endpackage : ccdseq_pkg
`default_nettype wire

// ===== rtl/ccdseq_sequencer.sv
// Full-frame CCD clock sequencer with pixel sample buffer
//
// Functional notes
// [RULE1] Pixel period never shorter than 41.67 ns
// [RULE2] Horizontal phases run at 50% duty; a full buffer stretches the first (A high) half
// [RULE3] Each vertical phase pulse lasts 8 us minimum
// [RULE4] Wait 5 us after vertical B falls
// [RULE5] Vertical A falling edge advances one row
// [RULE6] Vertical B falling edge loads horizontal register
// [RULE7] 3695 rows, each at least 219 us
// [RULE8] Rows past 3695 carry only empty packets
// [RULE9] Shift 4641 pixels per line
// [RULE10] Integration is time vertical clocks stay static
// [RULE11] Integration duration is a programmable input
// [RULE12] Vertical phases low throughout integration
// [RULE13] Horizontal A high while vertical B falls
// [RULE14] Horizontal phases toggle complementary, alternately
// [RULE15] Final horizontal phase fall dumps packet
// [RULE16] Reset gate pulses once per pixel period
// [RULE17] After frame, return to static integration state
`default_nettype none
module ccdseq_sequencer
  import ccdseq_pkg::*;
#(
  parameter int unsigned ROWS = ROW_COUNT,
  parameter int unsigned PIXELS = PIXEL_COUNT,
  parameter int unsigned LINE_CYC = LINE_MIN_CYC,
  parameter int unsigned VPULSE_CYC = V_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = VH_SETTLE_CYC,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the camera logic
  input wire logic start_i,
  input wire logic [31:0] integ_cycles_i,
  output logic busy_o,
  output logic frame_done_o,
  // Sensor clock pins
  output logic vertical_phase_a_o,
  output logic vertical_phase_b_o,
  output logic horizontal_phase_a_o,
  output logic horizontal_phase_b_o,
  output logic final_horizontal_phase_o,
  output logic output_reset_gate_o,
  // Digitised video from the converter, same clock
  input wire logic [VIDEO_W-1:0] video_i,
  // Pixel stream out
  output logic pix_valid_o,
  output ccdseq_pixel_t pix_data_o,
  input wire logic pix_ready_i
);
  ccdseq_state_t st_reg, st_next;  // Sequencer state
  logic [31:0] tmr_reg, tmr_next;  // Phase timer
  logic [15:0] line_reg, line_next;  // Cycles since row start
  logic [11:0] row_reg, row_next;  // Rows transferred
  logic [12:0] pix_reg, pix_next;  // Pixels shifted in this line
  logic ph_reg, ph_next;  // Pixel half: 0 first, 1 second
  logic [7:0] half_reg, half_next;  // Cycles into the half
  ccdseq_clocks_t clk_reg, clk_next;  // Registered pin levels
  logic done_reg, done_next;  // Frame end pulse
  logic busy_reg, busy_next;  // Frame in progress
  logic push;  // Sample into buffer
  ccdseq_pixel_t push_data;
  logic fifo_ready;  // Buffer has room
  logic fifo_valid;
  ccdseq_pixel_t fifo_data;
  logic half_end;

  // Next-state logic for sequence, counters and pins
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg + 32'h1;
    line_next = (line_reg == 16'hffff) ? line_reg : line_reg + 16'h1;
    row_next = row_reg;
    pix_next = pix_reg;
    ph_next = ph_reg;
    half_next = half_reg;
    done_next = 1'b0;
    push = 1'b0;
    push_data.row = row_reg;
    push_data.line_end = (pix_reg == 13'(PIXELS - 1));
    push_data.video = video_i;
    half_end = (half_reg == 8'(PIX_HALF_CYC - 1));
    case (st_reg)
      CCDSEQ_IDLE: begin
        // Vertical clocks static, charge keeps integrating
        tmr_next = 32'h0;
        if (start_i) begin
          st_next = CCDSEQ_INTEG;
        end
      end
      CCDSEQ_INTEG: begin
        // Exposure length taken from the control input
        if (tmr_reg >= integ_cycles_i) begin  // RULE11
          st_next = CCDSEQ_VA_HIGH;
          tmr_next = 32'h0;
          line_next = 16'h0;
        end
      end
      CCDSEQ_VA_HIGH: begin
        if (tmr_reg >= 32'(VPULSE_CYC - 1)) begin  // RULE3
          st_next = CCDSEQ_VB_HIGH;  // RULE5
          tmr_next = 32'h0;
        end
      end
      CCDSEQ_VB_HIGH: begin
        if (tmr_reg >= 32'(VPULSE_CYC - 1)) begin  // RULE3
          st_next = CCDSEQ_SETTLE;  // RULE6
          tmr_next = 32'h0;
        end
      end
      CCDSEQ_SETTLE: begin
        // Let charge finish moving into the horizontal register
        if (tmr_reg >= 32'(SETTLE_CYC - 1)) begin  // RULE4
          st_next = CCDSEQ_SHIFT;
          pix_next = 13'h0;
          ph_next = 1'b0;
          half_next = 8'h0;
        end
      end
      CCDSEQ_SHIFT: begin
        if (!half_end) begin
          half_next = half_reg + 8'h1;
        end else if (!ph_reg) begin
          // Stall in the first half while the buffer is full, so no
          // pixel is ever lost; the line simply stretches
          if (fifo_ready) begin
            ph_next = 1'b1;  // RULE15
            half_next = 8'h0;
          end
        end else begin
          // Sample at the end of the second half, output settled
          push = 1'b1;
          half_next = 8'h0;
          ph_next = 1'b0;
          pix_next = pix_reg + 13'h1;
          if (pix_reg == 13'(PIXELS - 1)) begin  // RULE9
            st_next = CCDSEQ_LINE_PAD;
          end
        end
      end
      CCDSEQ_LINE_PAD: begin
        // Stretch short lines up to the least line time
        if (line_reg >= 16'(LINE_CYC - 1)) begin  // RULE7
          tmr_next = 32'h0;
          line_next = 16'h0;
          row_next = row_reg + 12'h1;
          if (row_reg == 12'(ROWS - 1)) begin  // RULE8
            st_next = CCDSEQ_IDLE;  // RULE17
            row_next = 12'h0;
            done_next = 1'b1;
          end else begin
            st_next = CCDSEQ_VA_HIGH;
          end
        end
      end
      default: begin
        st_next = CCDSEQ_IDLE;
      end
    endcase
    busy_next = (st_next != CCDSEQ_IDLE);
    // Pin levels follow the next state so they leave flip-flops
    clk_next.vertical_phase_a = (st_next == CCDSEQ_VA_HIGH);  // RULE12 RULE10
    clk_next.vertical_phase_b = (st_next == CCDSEQ_VB_HIGH);  // RULE12
    if (st_next == CCDSEQ_SHIFT) begin
      clk_next.horizontal_phase_a = !ph_next;  // RULE14
      clk_next.horizontal_phase_b = ph_next;  // RULE14 RULE2
      clk_next.final_horizontal_phase = !ph_next;
      clk_next.output_reset_gate = !ph_next;  // RULE16
    end else begin
      // Horizontal A parked high across every vertical transfer
      clk_next.horizontal_phase_a = 1'b1;  // RULE13
      clk_next.horizontal_phase_b = 1'b0;
      clk_next.final_horizontal_phase = 1'b1;
      clk_next.output_reset_gate = 1'b1;
    end
  end

  // State registers; the pixel half of PIX_HALF_CYC cycles keeps the
  // pixel period at or above the least figure
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= CCDSEQ_IDLE;
      tmr_reg <= 32'h0;
      line_reg <= 16'h0;
      row_reg <= 12'h0;
      pix_reg <= 13'h0;
      ph_reg <= 1'b0;
      half_reg <= 8'h0;
      clk_reg <= PINS_IDLE;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      line_reg <= line_next;
      row_reg <= row_next;
      pix_reg <= pix_next;
      ph_reg <= ph_next;  // RULE1
      half_reg <= half_next;
      clk_reg <= clk_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  // Sample buffer between the converter and the stream
  ccdseq_fifo #(
    .WIDTH($bits(ccdseq_pixel_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(push_data),
    .in_ready_o(fifo_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pix_ready_i)
  );

  assign busy_o = busy_reg;
  assign frame_done_o = done_reg;
  assign vertical_phase_a_o = clk_reg.vertical_phase_a;
  assign vertical_phase_b_o = clk_reg.vertical_phase_b;
  assign horizontal_phase_a_o = clk_reg.horizontal_phase_a;
  assign horizontal_phase_b_o = clk_reg.horizontal_phase_b;
  assign final_horizontal_phase_o = clk_reg.final_horizontal_phase;
  assign output_reset_gate_o = clk_reg.output_reset_gate;
  assign pix_valid_o = fifo_valid;
  assign pix_data_o = fifo_data;
endmodule : ccdseq_sequencer
`default_nettype wire
